// ### rtl/flash_seq_params.svh
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH

// ==========================================================================
// Register offsets (byte addresses on the APB side).
`define OFF_CTRL            8'h00
`define OFF_PROT            8'h04
`define OFF_ADDR            8'h08
`define OFF_DATA            8'h0c
`define OFF_STAT            8'h10
`define OFF_RDAT            8'h14

// ==========================================================================
// Field positions.
`define CTRL_PGM_BIT        0
`define CTRL_ERASE_BIT      1
`define CTRL_MASS_BIT       2
`define CTRL_HV_BIT         3
`define STAT_ROW_FAIL_BIT   0
`define STAT_REFUSED_BIT    1
`define STAT_STANDBY_BIT    2
`define STAT_BYPASS_BIT     3
`define STAT_NVS_DONE_BIT   4

// ==========================================================================
// Reset values.
`define ADDR_RESET          16'h0000
`define DATA_RESET          8'hff

// ==========================================================================
// Array geometry and protection.
`define ROW_LSB             5
`define PROTECT_BYTE_ADDR   16'hff7e
`define PROTECT_OPEN        8'hff
`define PROTECT_TOP_BITS    2'b11
`define PROTECT_LOW_ZERO    6'h00

// ==========================================================================
// Timing.
`define CLK_PERIOD_NS       8
`define NVS_TIME_NS         10000
`define NVS_CYCLES          ((`NVS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NVS_CNT_W           11

`endif

// ### rtl/flash_seq_pkg.sv
`default_nettype none
package flash_seq_pkg;

  // ========================================================================
  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    st_idle     = 5'b00001,
    st_selected = 5'b00010,
    st_armed    = 5'b00100,
    st_latched  = 5'b01000,
    st_hv       = 5'b10000
  } seq_state_t;

endpackage : flash_seq_pkg
`default_nettype wire

// ### rtl/protect_range.sv
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_params.svh"

module protect_range (
  input  wire logic [7:0]  protect_start_bits, // Protect byte read from the array.
  input  wire logic        test_high_voltage,  // Test voltage seen on the interrupt pin.
  input  wire logic [15:0] target_addr,        // Address the operation aims at.
  input  wire logic        mass_op,            // Operation is a mass erase.
  output var  logic        blocked             // Operation must be refused.
);
  import flash_seq_pkg::*;

  logic [15:0] start_addr;
  logic        open_all;

  // ========================================================================
  // Start address and range test.
  assign start_addr = {`PROTECT_TOP_BITS, protect_start_bits, `PROTECT_LOW_ZERO};
  assign open_all   = (protect_start_bits == `PROTECT_OPEN);

  always_comb begin
    if (test_high_voltage || open_all) begin
      blocked = 1'b0;
    end else if (mass_op) begin
      blocked = 1'b1;
    end else begin
      blocked = (target_addr >= start_addr)
             || (target_addr == `PROTECT_BYTE_ADDR);
    end
  end

endmodule : protect_range
`default_nettype wire

// ### rtl/flash_row_program_protect.sv
// Notes on behaviour
// - Program in 32-byte rows aligned to 32-byte boundaries.
// - Byte writes outside the latched row in one cycle fail and are flagged.
// - Program-select configures programming and enables address and data capture.
// - High-voltage enable is refused when the target is protected.
// - Protect byte zero protects all; all ones protects nothing.
// - With protection on, the protect byte itself cannot change.
// - Mass erase is refused whenever the protect byte is not all ones and no test high voltage is present.
// - Test high voltage on the interrupt pin bypasses all protection.
// - Protect byte has no guard of its own when unprotected.
// - Start address: ones, protect byte as bits 13..6, six zeros.
// - Protection runs from start address to top of memory inclusive.
// - Start at array base protects everything; all ones protects nothing.
// - Wait or stop aborts any operation into standby.
// - In standby every flash control output is inactive.
// - HV sets only with a select bit and the proper sequence done.
// - Program-select and erase-select are never both one.
// - Erased bits read one; programming can only turn ones to zero.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_params.svh"

module flash_row_program_protect (
  input  wire logic                     pclk,                // APB clock, 125 MHz.
  input  wire logic                     presetn,             // Asynchronous reset.
  input  wire logic                     psel,                // APB select.
  input  wire logic                     penable,             // APB enable.
  input  wire logic                     pwrite,              // APB direction.
  input  wire logic [7:0]               paddr,               // APB byte address.
  input  wire logic [31:0]              pwdata,              // APB write data.
  output var  logic                     pready,              // APB ready.
  output var  logic [31:0]              prdata,              // APB read data.
  output var  logic                     pslverr,             // APB error.
  input  wire logic [7:0]               protect_start_bits,  // Protect byte from array.
  input  wire logic [7:0]               flash_rdata,         // Array byte at flash_addr.
  input  wire logic                     test_high_voltage,   // Test voltage detected.
  input  wire logic                     low_power_req,       // Wait or stop entered.
  output var  logic [15:0]              flash_addr,          // Array address.
  output var  logic [7:0]               flash_wdata,         // Byte to program.
  output var  logic                     flash_wr,            // Byte program strobe.
  output var  logic                     program_select,      // Program mode.
  output var  logic                     erase_select,        // Erase mode.
  output var  logic                     mass_select,         // Mass erase mode.
  output var  logic                     high_voltage_enable, // Charge pump on.
  output var  logic                     standby              // Flash in standby.
);
  import flash_seq_pkg::*;

  localparam int                    NVS_CYC  = `NVS_CYCLES;
  localparam logic [`NVS_CNT_W-1:0] NVS_LOAD = NVS_CYC[`NVS_CNT_W-1:0];

  // ========================================================================
  // State.
  flash_seq_pkg::seq_state_t state_q, state_d;
  logic                  pgm_q, pgm_d, er_q, er_d, mass_q, mass_d, hv_q, hv_d;
  logic [15:0]           addr_q, addr_d, lat_q, lat_d;
  logic [`NVS_CNT_W-1:0] cnt_q, cnt_d;
  logic                  fail_q, fail_d, refused_q, refused_d;
  logic                  standby_q, standby_d, wr_q, wr_d;
  logic [7:0]            wdata_q, wdata_d;
  logic                  pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0]           prdata_q, prdata_d;

  logic        bus_take, wr_done, rd_done, set_fail, set_refused;
  logic        want_pgm, want_er, want_mass, want_hv, blocked, nvs_done;
  logic        clr_fail, clr_refused, mass_op;
  logic [15:0] check_addr;

  function automatic logic [10:0] row_of(input logic [15:0] a);
    return a[15:`ROW_LSB];
  endfunction : row_of

  // ========================================================================
  // APB handshake: one wait state, effects at the completing edge.
  assign bus_take  = psel & penable & ~pready_q;
  assign wr_done   = psel & penable & pready_q & pwrite;
  assign rd_done   = psel & penable & pready_q & ~pwrite;
  assign want_pgm  = pwdata[`CTRL_PGM_BIT];
  assign want_er   = pwdata[`CTRL_ERASE_BIT];
  assign want_mass = pwdata[`CTRL_MASS_BIT];
  assign want_hv   = pwdata[`CTRL_HV_BIT];
  assign nvs_done  = (cnt_q == '0);
  assign clr_fail    = wr_done && (paddr == `OFF_STAT) && pwdata[`STAT_ROW_FAIL_BIT];
  assign clr_refused = wr_done && (paddr == `OFF_STAT) && pwdata[`STAT_REFUSED_BIT];
  // A mass erase asked for in the same write as high voltage is checked as well.
  assign mass_op     = er_q & (mass_q | (wr_done && (paddr == `OFF_CTRL) && want_mass));

  // The row latch address is checked at high-voltage time, each byte after.
  assign check_addr = (state_q == st_hv) ? addr_q : lat_q;

  protect_range u_protect (
    .protect_start_bits (protect_start_bits),
    .test_high_voltage  (test_high_voltage),
    .target_addr        (check_addr),
    .mass_op            (mass_op),
    .blocked            (blocked)
  );

  // ========================================================================
  // Sequencer.
  always_comb begin
    state_d     = state_q;
    pgm_d       = pgm_q;
    er_d        = er_q;
    mass_d      = mass_q;
    hv_d        = hv_q;
    addr_d      = addr_q;
    lat_d       = lat_q;
    cnt_d       = cnt_q;
    wdata_d     = wdata_q;
    wr_d        = 1'b0;
    standby_d   = 1'b0;
    set_fail    = 1'b0;
    set_refused = 1'b0;
    if ((state_q == st_latched) && !nvs_done) begin
      cnt_d = cnt_q - 1'b1;
    end
    if (wr_done && (paddr == `OFF_CTRL)) begin
      if (!(want_pgm && want_er) && !(want_er && !er_q && pgm_q)
          && !(want_pgm && !pgm_q && er_q)) begin
        pgm_d = want_pgm;
        er_d  = want_er;
        if ((want_pgm && !pgm_q) || (want_er && !er_q)) begin
          state_d = st_selected;
        end
      end
      // Mass may only rise with the pump off, so the high-voltage check covers it.
      mass_d = want_mass & (mass_q | ~hv_q);
      if (want_hv && !hv_q) begin
        if ((state_q == st_latched) && nvs_done && (pgm_d || er_d) && !blocked) begin
          hv_d    = 1'b1;
          state_d = st_hv;
        end else begin
          set_refused = 1'b1;
        end
      end else if (!want_hv) begin
        hv_d = 1'b0;
      end
      if (!hv_d && !pgm_d && !er_d) begin
        state_d = st_idle;
      end else if ((state_q == st_hv) && !hv_d) begin
        state_d = st_selected;
      end
    end
    // Reading the protect byte after a select arms the row latch.
    if (rd_done && (paddr == `OFF_PROT) && (state_q == st_selected)) begin
      state_d = st_armed;
    end
    if (wr_done && (paddr == `OFF_ADDR)) begin
      addr_d = pwdata[15:0];
    end
    if (wr_done && (paddr == `OFF_DATA)) begin
      if (state_q == st_armed) begin
        lat_d   = addr_q;
        cnt_d   = NVS_LOAD;
        state_d = st_latched;
      end else if ((state_q == st_latched) || (state_q == st_hv && pgm_q)) begin
        if (row_of(addr_q) != row_of(lat_q)) begin
          set_fail = 1'b1;
        end else if (state_q == st_hv) begin
          if (blocked) begin
            set_refused = 1'b1;
          end else begin
            wr_d    = 1'b1;
            wdata_d = pwdata[7:0] & flash_rdata;
          end
        end
      end
    end
    if (low_power_req) begin
      pgm_d     = 1'b0;
      er_d      = 1'b0;
      mass_d    = 1'b0;
      hv_d      = 1'b0;
      wr_d      = 1'b0;
      state_d   = st_idle;
      standby_d = 1'b1;
    end
    // A flag raised in the clearing cycle survives.
    fail_d    = set_fail | (fail_q & ~clr_fail);
    refused_d = set_refused | (refused_q & ~clr_refused);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= st_idle;
      pgm_q     <= 1'b0;
      er_q      <= 1'b0;
      mass_q    <= 1'b0;
      hv_q      <= 1'b0;
      addr_q    <= `ADDR_RESET;
      lat_q     <= `ADDR_RESET;
      cnt_q     <= '0;
      wdata_q   <= `DATA_RESET;
      wr_q      <= 1'b0;
      standby_q <= 1'b0;
      fail_q    <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      pgm_q     <= pgm_d;
      er_q      <= er_d;
      mass_q    <= mass_d;
      hv_q      <= hv_d;
      addr_q    <= addr_d;
      lat_q     <= lat_d;
      cnt_q     <= cnt_d;
      wdata_q   <= wdata_d;
      wr_q      <= wr_d;
      standby_q <= standby_d;
      fail_q    <= fail_d;
      refused_q <= refused_d;
    end
  end

  // ========================================================================
  // APB answer.
  always_comb begin
    pready_d  = bus_take;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    if (bus_take) begin
      prdata_d = 32'h0000_0000;
      case (paddr)
        `OFF_CTRL: prdata_d = {28'h000_0000, hv_q, mass_q, er_q, pgm_q};
        `OFF_PROT: prdata_d = {24'h00_0000, protect_start_bits};
        `OFF_ADDR: prdata_d = {16'h0000, addr_q};
        `OFF_DATA: prdata_d = 32'h0000_0000;
        `OFF_STAT: prdata_d = {27'h000_0000, nvs_done, test_high_voltage,
                               standby_q, refused_q, fail_q};
        `OFF_RDAT: prdata_d = {24'h00_0000, flash_rdata};
        default:   pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign prdata              = prdata_q;
  assign flash_addr          = addr_q;
  assign flash_wdata         = wdata_q;
  assign flash_wr            = wr_q;
  assign program_select      = pgm_q;
  assign erase_select        = er_q;
  assign mass_select         = mass_q;
  assign high_voltage_enable = hv_q;
  assign standby             = standby_q;

  // ========================================================================
  // Checks.
  chk_select_interlock: assert property (@(posedge pclk) disable iff (!presetn)
    !(pgm_q && er_q)) else $error("program and erase selected together");

  chk_hv_needs_sequence: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(hv_q) |-> (pgm_q || er_q) && $past(state_q) == st_latched
      && $past(cnt_q) == '0) else $error("high voltage set out of sequence");

  chk_hv_not_protected: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(hv_q) |-> $past(!blocked)) else $error("high voltage set on protected target");

  chk_mass_locked: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(hv_q) && er_q && mass_q |->
      $past(protect_start_bits) == `PROTECT_OPEN || $past(test_high_voltage))
    else $error("mass erase started with protection on");

  chk_nvs_wait: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_q == st_latched) |-> cnt_q == NVS_LOAD
      ##1 (state_q != st_hv) [*8]) else $error("row latch delay not loaded");

  chk_low_power_abort: assert property (@(posedge pclk) disable iff (!presetn)
    low_power_req |=> standby_q && !hv_q && state_q == st_idle)
    else $error("low power did not abort the operation");

  chk_standby_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    standby_q |-> !hv_q && !pgm_q && !er_q && !mass_q && !wr_q)
    else $error("control active in standby");

  chk_byte_in_row: assert property (@(posedge pclk) disable iff (!presetn)
    wr_q |-> row_of(addr_q) == row_of(lat_q) && hv_q && pgm_q)
    else $error("byte programmed outside the latched row");

  chk_row_fail_flag: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && paddr == `OFF_DATA && pgm_q && state_q == st_hv && !low_power_req
      && row_of(addr_q) != row_of(lat_q) |=> fail_q && !wr_q)
    else $error("cross-row write not flagged");

  chk_only_clears_bits: assert property (@(posedge pclk) disable iff (!presetn)
    wr_q |-> (wdata_q & ~$past(flash_rdata)) == 8'h00)
    else $error("program would raise an erased bit");

  chk_apb_single_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("ready not a single cycle pulse");

endmodule : flash_row_program_protect
`default_nettype wire

// ### testbench/flash_array_model.sv
`timescale 1ns/10ps
`default_nettype none

module flash_array_model (
  input  wire logic        pclk,               // Clock.
  input  wire logic [15:0] flash_addr,         // Array address.
  input  wire logic [7:0]  flash_wdata,        // Byte to program.
  input  wire logic        flash_wr,           // Program strobe.
  output var  logic [7:0]  protect_start_bits, // Protect byte location.
  output var  logic [7:0]  flash_rdata         // Byte at flash_addr.
);
  // ========================================================================
  // Array storage, erased at start.
  logic [7:0] mem [0:65535];

  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
  end

  // Programming can only pull bits to zero.
  always @(posedge pclk) begin
    if (flash_wr === 1'b1) mem[flash_addr] <= mem[flash_addr] & flash_wdata;
  end

  // The protect byte is an ordinary array location.
  assign protect_start_bits = mem[16'hff7e];
  assign flash_rdata        = mem[flash_addr];
endmodule : flash_array_model

`default_nettype wire

// ### testbench/test_flash_row_program_protect.sv
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_params.svh"

module test_flash_row_program_protect;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        test_high_voltage, low_power_req, flash_wr, program_select;
  logic        erase_select, mass_select, high_voltage_enable, standby;
  logic [7:0]  paddr, protect_start_bits, flash_rdata, flash_wdata;
  logic [15:0] flash_addr;
  logic [31:0] pwdata, prdata, rd;
  int          err_count, n_checks, wr_count, n;

  flash_row_program_protect uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .protect_start_bits, .flash_rdata,
    .test_high_voltage, .low_power_req, .flash_addr, .flash_wdata, .flash_wr,
    .program_select, .erase_select, .mass_select, .high_voltage_enable, .standby);
  flash_array_model arr (.pclk, .flash_addr, .flash_wdata, .flash_wr,
    .protect_start_bits, .flash_rdata);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Counted mid-cycle so that a check after a clock edge never races the count.
  always @(negedge pclk) begin
    if (flash_wr === 1'b1) wr_count++;
  end

  // ========================================================================
  // Reporting.
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask : chk

  // ========================================================================
  // APB master: setup, then access until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      $display("CHECK FAILED pready expected 1 seen %b", pready);
      err_count++;
      summarize();
    end else begin
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb

  task automatic wait_us(input int us);
    repeat (us * 1000 / `CLK_PERIOD_NS) @(posedge pclk);
  endtask : wait_us

  task automatic wait_nvs();
    for (int i = 0; i < 600; i++) begin
      apb(1'b0, `OFF_STAT, 32'h0);
      if (rd[4] === 1'b1) return;
    end
    chk("nvs_done", 32'h1, 32'h0);
    summarize();
  endtask : wait_nvs

  task automatic prep(input logic [2:0] sel, input logic [15:0] a, input logic [7:0] pb);
    apb(1'b1, `OFF_CTRL, {29'h0, sel});
    chk("mass_select", {31'h0, sel[2]}, {31'h0, mass_select});
    apb(1'b0, `OFF_PROT, 32'h0);
    chk("prot", {24'h0, pb}, rd);
    // Without a monitor mode the row-select write always targets the array.
    apb(1'b1, `OFF_ADDR, {16'h0, a});
    apb(1'b1, `OFF_DATA, 32'h0);
    wait_nvs();
  endtask : prep

  // One high-voltage attempt against the protection logic.
  task automatic try_hv(input logic [7:0] pb, input logic [15:0] a, input logic tv,
                        input logic [2:0] sel, input logic blk);
    arr.mem[16'hff7e] = pb;
    test_high_voltage <= tv;
    prep(sel, a, pb);
    apb(1'b1, `OFF_CTRL, {28'h0, 1'b1, sel});
    chk("hv_enable", {31'h0, ~blk}, {31'h0, high_voltage_enable});
    apb(1'b0, `OFF_STAT, 32'h0);
    chk("stat", {28'h0, tv, 1'b0, blk, 1'b0}, {28'h0, rd[3:0]});
    apb(1'b1, `OFF_CTRL, {28'h0, ~blk, 3'h0});
    wait_us(5);
    apb(1'b1, `OFF_CTRL, 32'h0);
    apb(1'b1, `OFF_STAT, 32'h3);
    $display("test protect %h addr %h tv %b sel %h done", pb, a, tv, sel);
  endtask : try_hv

  // ========================================================================
  // Main sequence.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    test_high_voltage = 1'b0;
    low_power_req = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `OFF_CTRL, 32'h0);
    chk("ctrl_reset", 32'h0, rd);
    apb(1'b1, `OFF_PROT, 32'h0);
    apb(1'b0, `OFF_PROT, 32'h0);
    chk("prot_ro", 32'h0000_00ff, rd);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    $display("test reset done");

    prep(3'h1, 16'he020, 8'hff);
    apb(1'b1, `OFF_CTRL, 32'h9);
    chk("hv_set", 32'h1, {31'h0, high_voltage_enable});
    wait_us(5);
    n = wr_count;
    apb(1'b1, `OFF_ADDR, 32'h0000_e025);
    apb(1'b1, `OFF_DATA, 32'h0000_005a);
    wait_us(30);
    apb(1'b1, `OFF_ADDR, 32'h0000_e03f);
    apb(1'b1, `OFF_DATA, 32'h0000_000f);
    wait_us(30);
    chk("wr_pulses", n + 2, wr_count);
    apb(1'b1, `OFF_ADDR, 32'h0000_e045);
    apb(1'b1, `OFF_DATA, 32'h0000_0033);
    chk("wr_other_row", n + 2, wr_count);
    apb(1'b0, `OFF_STAT, 32'h0);
    chk("row_fail", 32'h1, {31'h0, rd[0]});
    apb(1'b1, `OFF_CTRL, 32'h8);
    wait_us(5);
    apb(1'b1, `OFF_CTRL, 32'h0);
    wait_us(1);
    apb(1'b1, `OFF_ADDR, 32'h0000_e025);
    apb(1'b0, `OFF_RDAT, 32'h0);
    chk("byte_e025", 32'h5a, rd);
    apb(1'b1, `OFF_ADDR, 32'h0000_e045);
    apb(1'b0, `OFF_RDAT, 32'h0);
    chk("byte_e045", 32'hff, rd);
    apb(1'b1, `OFF_STAT, 32'h3);
    apb(1'b0, `OFF_STAT, 32'h0);
    chk("stat_clear", 32'h0, {30'h0, rd[1:0]});
    $display("test row program done");

    apb(1'b1, `OFF_CTRL, 32'h1);
    apb(1'b1, `OFF_CTRL, 32'h9);
    chk("hv_early", 32'h0, {31'h0, high_voltage_enable});
    apb(1'b1, `OFF_CTRL, 32'h2);
    apb(1'b0, `OFF_CTRL, 32'h0);
    chk("interlock_a", 32'h1, {28'h0, rd[3:0]});
    apb(1'b1, `OFF_CTRL, 32'h0);
    apb(1'b1, `OFF_CTRL, 32'h3);
    chk("interlock_b", 32'h0, {30'h0, erase_select, program_select});
    apb(1'b1, `OFF_STAT, 32'h3);
    $display("test interlock done");

    try_hv(8'h80, 16'he000, 1'b0, 3'h1, 1'b1);
    try_hv(8'h00, 16'he000, 1'b0, 3'h2, 1'b1);
    try_hv(8'h81, 16'he040, 1'b0, 3'h1, 1'b1);
    try_hv(8'h81, 16'he03f, 1'b0, 3'h2, 1'b0);
    try_hv(8'hfe, 16'hff80, 1'b0, 3'h1, 1'b1);
    try_hv(8'hfe, 16'hffff, 1'b0, 3'h2, 1'b1);
    try_hv(8'hfe, 16'hff60, 1'b0, 3'h1, 1'b0);
    try_hv(8'hfe, 16'hff7e, 1'b0, 3'h1, 1'b1);
    try_hv(8'h81, 16'he040, 1'b1, 3'h1, 1'b0);
    try_hv(8'hfe, 16'he000, 1'b0, 3'h6, 1'b1);
    try_hv(8'hfe, 16'he000, 1'b1, 3'h6, 1'b0);
    try_hv(8'hff, 16'he000, 1'b0, 3'h6, 1'b0);

    test_high_voltage <= 1'b0;
    prep(3'h1, 16'he0c0, 8'hff);
    apb(1'b1, `OFF_CTRL, 32'h9);
    low_power_req <= 1'b1;
    @(posedge pclk);
    low_power_req <= 1'b0;
    @(negedge pclk);
    chk("standby", 32'h1, {31'h0, standby});
    chk("ctrl_out", 32'h0, {28'h0, high_voltage_enable, mass_select, erase_select,
        program_select});
    @(posedge pclk);
    apb(1'b0, `OFF_CTRL, 32'h0);
    chk("ctrl_after", 32'h0, {28'h0, rd[3:0]});
    $display("test standby done");
    summarize();
  end
endmodule : test_flash_row_program_protect

`default_nettype wire
